/* sdram_write_refresh_rules_tb.sv */
// Purpose: Drives the controller user side and checks what the memory end delivers
// Assumes: Default latencies; DW of 8 so one write carries 64 bits
// Notes: The refresh deferral spell makes the run several thousand cycles
`timescale 1ns/1ps
module sdram_write_refresh_rules_tb;
	localparam int WL = sdwr_pkg::AL_DEF + sdwr_pkg::CWL_DEF;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr_valid = 1'b0;
	logic mode_load = 1'b0;
	logic pull_in_en = 1'b0;
	logic wr_chop = 1'b0;
	logic [2:0] wr_bank = 3'h0;
	logic [15:0] wr_row = 16'h0000;
	logic [9:0] wr_col = 10'h000;
	logic [63:0] wr_data = 64'h0000_0000_0000_0000;
	logic [1:0] mode_burst = 2'h0;
	logic wr_ready, rd_allowed, busy, d_valid, ref_pulse, ref_busy, banks_idle;
	logic signed [4:0] ref_owed;
	logic signed [4:0] max_owed = 5'sh00;
	logic [2:0] d_bank;
	logic [15:0] d_row, ref_row, d_data;
	logic [9:0] d_col;
	logic [1:0] d_mode;
	logic [44:0] got_q[$];
	int miscompares = 0;
	int checks = 0;
	int refs = 0;
	int busy_run = 0;
	sdwr_if #(.DW(8)) lnk ();
	sdwr_ctl #(.DW(8)) u_sdwr_ctl (.clk(clk), .rstn(rstn), .link(lnk.ctl), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_bank(wr_bank), .wr_row(wr_row), .wr_col(wr_col), .wr_chop(wr_chop), .wr_data(wr_data),
		.mode_load(mode_load), .mode_burst(mode_burst), .pull_in_en(pull_in_en), .ref_owed(ref_owed),
		.rd_allowed(rd_allowed), .busy(busy));
	sdwr_dev #(.DW(8)) u_sdwr_dev (.clk(clk), .rstn(rstn), .link(lnk.dev), .wr_valid(d_valid), .wr_bank(d_bank),
		.wr_row(d_row), .wr_col(d_col), .wr_data(d_data), .ref_pulse(ref_pulse), .ref_row(ref_row),
		.ref_busy(ref_busy), .mode_burst(d_mode), .banks_idle(banks_idle));
	sdwr_props #(.DW(8)) u_sdwr_props (.clk(clk), .rstn(rstn), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
		.cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr), .dq(lnk.dq));
	always #5 clk = ~clk;
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic give_up(input string what);
		miscompares++;
		$display("[FAIL] %s expected done seen timeout", what);
		close_out();
	endtask
	// Outputs are flops, so sampling at the falling edge avoids edge races
	always @(negedge clk) begin
		if (d_valid === 1'b1) got_q.push_back({d_bank, d_row, d_col, d_data});
		if (ref_pulse === 1'b1) refs++;
		if (ref_owed > max_owed) max_owed = ref_owed;
		if (ref_busy === 1'b1) busy_run++;
		else if (busy_run != 0) begin
			chk("ref_busy_len", sdwr_pkg::REFRESH_CYCLE_TIME_CYC, busy_run);
			busy_run = 0;
		end
	end
	task automatic set_mode(input logic [1:0] m);
		@(posedge clk);
		mode_burst <= m;
		mode_load <= 1'b1;
		@(posedge clk);
		mode_load <= 1'b0;
		repeat (8) @(negedge clk);
		chk("mode_burst", m, d_mode);
	endtask
	task automatic do_write(input logic [2:0] b, input logic [15:0] r, input logic [9:0] c, input logic ch,
		input logic [63:0] d, input logic ec);
		int n;
		int np;
		int ra;
		np = ec ? 2 : 4;
		ra = -1;
		n = 0;
		@(posedge clk);
		wr_valid <= 1'b1;
		wr_bank <= b;
		wr_row <= r;
		wr_col <= c;
		wr_chop <= ch;
		wr_data <= d;
		do begin @(negedge clk); n++; end while (wr_ready !== 1'b1 && n < 200);
		if (n >= 200) give_up("wr_ready");
		@(posedge clk);
		wr_valid <= 1'b0;
		n = 0;
		do begin @(negedge clk); n++; end
		while ({lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} !== sdwr_pkg::CMD_WR && n < 50);
		if (n >= 50) give_up("write command");
		if (d_mode === sdwr_pkg::BURST_OTF) chk("burst_select", !ec, lnk.addr[12]);
		chk("rd_blocked", 0, rd_allowed);
		for (int k = 1; k <= WL + 14; k++) begin
			@(negedge clk);
			if (k >= WL && k < WL + np) chk("dq_pair", d[16*(k-WL) +: 16], lnk.dq);
			if (rd_allowed === 1'b1 && ra < 0) ra = k;
		end
		chk("wtr_cycles", WL + np + sdwr_pkg::WRITE_TO_READ_DELAY_CYC, ra);
		n = 0;
		while (busy !== 1'b0 && n < 50) begin @(negedge clk); n++; end
		chk("pair_count", np, got_q.size());
		for (int p = 0; p < np && got_q.size() > 0; p++)
			chk("pair", {b, r, c[9:3], 3'(c[2:0] + 3'(2*p)), d[16*p +: 16]}, got_q.pop_front());
		got_q.delete();
		chk("banks_idle", 1, banks_idle);
	endtask
	initial begin
		int n;
		int r0;
		logic [15:0] rw;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("reset_state", {5'h00, 3'h5}, {ref_owed, rd_allowed, busy, banks_idle});
		set_mode(sdwr_pkg::BURST_BL8);
		do_write(3'h1, 16'h1234, 10'h000, 1'b1, 64'h0123_4567_89AB_CDEF, 1'b0);
		set_mode(sdwr_pkg::BURST_BC4);
		do_write(3'h2, 16'h0042, 10'h016, 1'b0, 64'hFEED_FACE_0BAD_F00D, 1'b1);
		set_mode(sdwr_pkg::BURST_OTF);
		do_write(3'h3, 16'hA5A5, 10'h3F8, 1'b0, 64'h1111_2222_3333_4444, 1'b0);
		do_write(3'h4, 16'h5A5A, 10'h016, 1'b1, 64'h5555_6666_7777_8888, 1'b1);
		r0 = refs;
		rw = ref_row;
		n = 0;
		while (refs == r0 && n < 1000) begin @(negedge clk); n++; end
		if (n >= 1000) give_up("refresh");
		repeat (14) @(negedge clk);
		chk("ref_row_step", rw + 16'h0001, ref_row);
		chk("idle_after_ref", 1, banks_idle);
		chk("owed_after_ref", 0, {ref_owed});
		@(posedge clk);
		wr_valid <= 1'b1;
		repeat (7200) @(posedge clk);
		wr_valid <= 1'b0;
		chk("owed_peak", 8, {max_owed});
		n = 0;
		while (ref_owed !== 5'sh00 && n < 400) begin @(negedge clk); n++; end
		chk("owed_drained", 0, {ref_owed});
		got_q.delete();
		repeat (1700) @(negedge clk);
		@(posedge clk);
		pull_in_en <= 1'b1;
		repeat (300) @(negedge clk);
		chk("owed_pulled", 5'h18, {ref_owed});
		@(posedge clk);
		pull_in_en <= 1'b0;
		close_out();
	end
endmodule

/* sdwr_ctl.sv */
// Purpose: Controller end: issues activate, write, precharge, refresh and mode commands
// Assumes: One bank open at a time; one write per activation
// Notes: Refresh debt is tracked as a signed count, negative when pulled in
`timescale 1ns/1ps
module sdwr_ctl #(
	parameter int AL = sdwr_pkg::AL_DEF,
	parameter int CAS_WRITE_LATENCY = sdwr_pkg::CWL_DEF,
	parameter int DW = sdwr_pkg::DW_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	sdwr_if.ctl link,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [2:0] wr_bank,
	input wire logic [sdwr_pkg::ADDR_W-1:0] wr_row,
	input wire logic [sdwr_pkg::COL_W-1:0] wr_col,
	input wire logic wr_chop,
	input wire logic [8*DW-1:0] wr_data,
	input wire logic mode_load,
	input wire logic [1:0] mode_burst,
	input wire logic pull_in_en,
	output logic signed [4:0] ref_owed,
	output logic rd_allowed,
	output logic busy
);
	localparam int WL = AL + CAS_WRITE_LATENCY;
	localparam int AW = sdwr_pkg::ADDR_W;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_MRS_WAIT = 3'h1,
		S_ACT_WAIT = 3'h2,
		S_WDATA = 3'h3,
		S_RP_WAIT = 3'h4,
		S_RFC_WAIT = 3'h5
	} sdwr_state_e;

	sdwr_state_e state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [15:0] refi_reg, refi_next;
	logic signed [4:0] owed_reg, owed_next;
	logic pend_reg, pend_next;
	logic [1:0] want_reg, want_next;
	logic [1:0] mode_reg, mode_next;
	logic [2:0] rbank_reg, rbank_next;
	logic [sdwr_pkg::COL_W-1:0] rcol_reg, rcol_next;
	logic rchop_reg, rchop_next;
	logic [8*DW-1:0] rdata_reg, rdata_next;
	logic [7:0] pairs_reg, pairs_next;
	logic [7:0] span_reg, span_next;
	logic [7:0] wtr_reg, wtr_next;
	logic [15:0] calm_reg, calm_next;
	sdwr_pkg::sdwr_cmd_t cmd_reg, cmd_next;
	logic [2:0] ba_reg, ba_next;
	logic [AW-1:0] addr_reg, addr_next;
	logic [2*DW-1:0] dq_reg, dq_next;
	logic tick;
	logic ref_want;
	logic ref_pull;
	logic [7:0] pidx;

	assign tick = (refi_reg == 16'(sdwr_pkg::REFRESH_INTERVAL_AVG_CYC - 1));
	// Postpone only while writes wait, and never past the limit
	assign ref_want = (owed_reg > 5'sd0) &&
		(!wr_valid || owed_reg >= $signed(5'(sdwr_pkg::MAX_POSTPONE)));
	// Pull-in waits two intervals after a late refresh, so a drained debt and a
	// full pull-in never fall into one window
	assign ref_pull = pull_in_en && !wr_valid &&
		(owed_reg > -$signed(5'(sdwr_pkg::MAX_PULL_IN))) &&
		(calm_reg >= 16'(2 * sdwr_pkg::REFRESH_INTERVAL_AVG_CYC));
	assign pidx = cnt_reg - 8'(WL - 1);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 8'h01;
		refi_next = tick ? 16'h0000 : refi_reg + 16'h0001;
		owed_next = owed_reg + (tick ? 5'sd1 : 5'sd0);
		pend_next = pend_reg;
		want_next = want_reg;
		mode_next = mode_reg;
		rbank_next = rbank_reg;
		rcol_next = rcol_reg;
		rchop_next = rchop_reg;
		rdata_next = rdata_reg;
		pairs_next = pairs_reg;
		span_next = span_reg;
		wtr_next = (wtr_reg != 8'h00) ? wtr_reg - 8'h01 : wtr_reg;
		calm_next = (calm_reg == 16'hFFFF) ? calm_reg : calm_reg + 16'h0001;
		cmd_next = sdwr_pkg::CMD_NOP;
		ba_next = ba_reg;
		addr_next = addr_reg;
		dq_next = dq_reg;
		if (mode_load) begin
			pend_next = 1'b1;
			want_next = mode_burst;
		end
		case (state_reg)
			S_IDLE: begin
				cnt_next = 8'h00;
				if (pend_reg) begin
					cmd_next = sdwr_pkg::CMD_MRS;
					ba_next = 3'h0;
					addr_next = {14'h0000, want_reg};
					mode_next = want_reg;
					pend_next = mode_load;
					state_next = S_MRS_WAIT;
				end else if (ref_want || ref_pull) begin
					// Idle means all banks closed and precharge time met
					cmd_next = sdwr_pkg::CMD_REF;
					owed_next = owed_next - 5'sd1;
					if (owed_reg > 5'sd1) begin
						calm_next = 16'h0000;
					end
					state_next = S_RFC_WAIT;
				end else if (wr_valid) begin
					cmd_next = sdwr_pkg::CMD_ACT;
					ba_next = wr_bank;
					addr_next = wr_row;
					rbank_next = wr_bank;
					rcol_next = wr_col;
					rdata_next = wr_data;
					rchop_next = (mode_reg == sdwr_pkg::BURST_BC4) ||
						((mode_reg == sdwr_pkg::BURST_OTF) && wr_chop);
					state_next = S_ACT_WAIT;
				end
			end
			S_MRS_WAIT: begin
				if (cnt_reg == 8'(sdwr_pkg::TMRD_CYC - 1)) begin
					state_next = S_IDLE;
				end
			end
			S_ACT_WAIT: begin
				if (cnt_reg == 8'(sdwr_pkg::TRCD_CYC - 1)) begin
					cmd_next = sdwr_pkg::CMD_WR;
					ba_next = rbank_reg;
					addr_next = '0;
					addr_next[sdwr_pkg::COL_W-1:0] = rcol_reg;
					addr_next[sdwr_pkg::BURST_SEL_BIT] = !rchop_reg;
					pairs_next = sdwr_pkg::sdwr_pairs(rchop_reg);
					// Per-command chop recovers from where an eight-beat burst ends
					span_next = (rchop_reg && mode_reg == sdwr_pkg::BURST_BC4) ?
						8'(sdwr_pkg::BC4_CLKS) : 8'(sdwr_pkg::CHOP_RECOV_CLKS);
					wtr_next = 8'(WL + sdwr_pkg::WRITE_TO_READ_DELAY_CYC) + sdwr_pkg::sdwr_pairs(rchop_reg);
					cnt_next = 8'h00;
					state_next = S_WDATA;
				end
			end
			S_WDATA: begin
				// Pair p must sit on the pins for the edge WL + p after the command
				if (cnt_reg >= 8'(WL - 1) && pidx < pairs_reg) begin
					dq_next = rdata_reg[pidx[1:0]*(2*DW) +: 2*DW];
				end
				// One write per activation keeps writes far more than four clocks apart
				if (cnt_reg == 8'(WL + sdwr_pkg::TWR_CYC - 1) + span_reg) begin
					cmd_next = sdwr_pkg::CMD_PRE;
					ba_next = rbank_reg;
					addr_next = '0;
					cnt_next = 8'h00;
					state_next = S_RP_WAIT;
				end
			end
			S_RP_WAIT: begin
				if (cnt_reg == 8'(sdwr_pkg::TRP_CYC - 1)) begin
					state_next = S_IDLE;
				end
			end
			S_RFC_WAIT: begin
				if (cnt_reg == 8'(sdwr_pkg::REFRESH_CYCLE_TIME_CYC - 1)) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= S_IDLE;
			cnt_reg <= 8'h00;
			refi_reg <= 16'h0000;
			owed_reg <= 5'sd0;
			pend_reg <= 1'b0;
			want_reg <= sdwr_pkg::BURST_BL8;
			mode_reg <= sdwr_pkg::BURST_BL8;
			rbank_reg <= 3'h0;
			rcol_reg <= '0;
			rchop_reg <= 1'b0;
			rdata_reg <= '0;
			pairs_reg <= 8'h00;
			span_reg <= 8'h00;
			wtr_reg <= 8'h00;
			calm_reg <= 16'h0000;
			cmd_reg <= sdwr_pkg::CMD_NOP;
			ba_reg <= 3'h0;
			addr_reg <= '0;
			dq_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			refi_reg <= refi_next;
			owed_reg <= owed_next;
			pend_reg <= pend_next;
			want_reg <= want_next;
			mode_reg <= mode_next;
			rbank_reg <= rbank_next;
			rcol_reg <= rcol_next;
			rchop_reg <= rchop_next;
			rdata_reg <= rdata_next;
			pairs_reg <= pairs_next;
			span_reg <= span_next;
			wtr_reg <= wtr_next;
			calm_reg <= calm_next;
			cmd_reg <= cmd_next;
			ba_reg <= ba_next;
			addr_reg <= addr_next;
			dq_reg <= dq_next;
		end
	end

	assign link.cs_n = cmd_reg[3];
	assign link.ras_n = cmd_reg[2];
	assign link.cas_n = cmd_reg[1];
	assign link.we_n = cmd_reg[0];
	assign link.ba = ba_reg;
	assign link.addr = addr_reg;
	assign link.dq = dq_reg;
	// Ready waits out a pending mode load and an overdue refresh
	assign wr_ready = (state_reg == S_IDLE) && !pend_reg && !ref_want;
	assign ref_owed = owed_reg;
	assign rd_allowed = (wtr_reg == 8'h00);
	assign busy = (state_reg != S_IDLE);
endmodule

/* sdwr_dev.sv */
// Purpose: Memory end: decodes commands, gathers write bursts, runs refresh cycles
// Assumes: Controller keeps all command spacing; pins synchronous to clk
// Notes: Writes are handed out on the user side one data pair per clock
`timescale 1ns/1ps
module sdwr_dev #(
	parameter int AL = sdwr_pkg::AL_DEF,
	parameter int CAS_WRITE_LATENCY = sdwr_pkg::CWL_DEF,
	parameter int DW = sdwr_pkg::DW_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	sdwr_if.dev link,
	output logic wr_valid,
	output logic [2:0] wr_bank,
	output logic [sdwr_pkg::ADDR_W-1:0] wr_row,
	output logic [sdwr_pkg::COL_W-1:0] wr_col,
	output logic [2*DW-1:0] wr_data,
	output logic ref_pulse,
	output logic [sdwr_pkg::ADDR_W-1:0] ref_row,
	output logic ref_busy,
	output logic [1:0] mode_burst,
	output logic banks_idle
);
	localparam int WL = AL + CAS_WRITE_LATENCY;
	localparam int AW = sdwr_pkg::ADDR_W;
	localparam int CW = sdwr_pkg::COL_W;

	logic [sdwr_pkg::BANKS-1:0] open_reg, open_next;
	logic [AW-1:0] row_reg [sdwr_pkg::BANKS], row_next [sdwr_pkg::BANKS];
	logic dl_v_reg [WL], dl_v_next [WL];
	logic dl_chop_reg [WL], dl_chop_next [WL];
	logic [2:0] dl_bank_reg [WL], dl_bank_next [WL];
	logic [CW-1:0] dl_col_reg [WL], dl_col_next [WL];
	logic [2:0] left_reg, left_next;
	logic [2:0] bbank_reg, bbank_next;
	logic [CW-1:0] bcol_reg, bcol_next;
	logic [7:0] rfc_reg, rfc_next;
	logic [1:0] mode_reg, mode_next;
	logic [AW-1:0] rrow_reg, rrow_next;
	logic rpulse_reg, rpulse_next;
	logic wv_reg, wv_next;
	logic [2:0] wb_reg, wb_next;
	logic [AW-1:0] wr_reg, wr_next;
	logic [CW-1:0] wc_reg, wc_next;
	logic [2*DW-1:0] wd_reg, wd_next;
	sdwr_pkg::sdwr_cmd_t cmd;

	assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

	always_comb begin
		open_next = open_reg;
		row_next = row_reg;
		mode_next = mode_reg;
		rrow_next = rrow_reg;
		rpulse_next = 1'b0;
		rfc_next = (rfc_reg != 8'h00) ? rfc_reg - 8'h01 : rfc_reg;
		left_next = left_reg;
		bbank_next = bbank_reg;
		bcol_next = bcol_reg;
		wv_next = 1'b0;
		wb_next = wb_reg;
		wr_next = wr_reg;
		wc_next = wc_reg;
		wd_next = wd_reg;
		dl_v_next[0] = 1'b0;
		dl_chop_next[0] = 1'b0;
		dl_bank_next[0] = 3'h0;
		dl_col_next[0] = '0;
		for (int i = 1; i < WL; i++) begin
			dl_v_next[i] = dl_v_reg[i-1];
			dl_chop_next[i] = dl_chop_reg[i-1];
			dl_bank_next[i] = dl_bank_reg[i-1];
			dl_col_next[i] = dl_col_reg[i-1];
		end
		// Commands arriving while a refresh runs are ignored
		if (rfc_reg == 8'h00) begin
			case (cmd)
				sdwr_pkg::CMD_ACT: begin
					open_next[link.ba] = 1'b1;
					row_next[link.ba] = link.addr;
				end
				sdwr_pkg::CMD_PRE: begin
					if (link.addr[sdwr_pkg::PRE_ALL_BIT]) begin
						open_next = '0;
					end else begin
						open_next[link.ba] = 1'b0;
					end
				end
				sdwr_pkg::CMD_WR: begin
					dl_v_next[0] = 1'b1;
					dl_bank_next[0] = link.ba;
					dl_col_next[0] = link.addr[CW-1:0];
					dl_chop_next[0] = sdwr_pkg::sdwr_is_chop(mode_reg, link.addr[sdwr_pkg::BURST_SEL_BIT]);
				end
				sdwr_pkg::CMD_REF: begin
					rfc_next = 8'(sdwr_pkg::REFRESH_CYCLE_TIME_CYC);
					rrow_next = rrow_reg + 16'h0001;
					rpulse_next = 1'b1;
				end
				sdwr_pkg::CMD_MRS: begin
					if (link.ba == 3'h0) begin
						mode_next = link.addr[1:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (rfc_reg == 8'h01) begin
			open_next = '0;
		end
		// A burst starts WL clocks after its command; a new start wins over a tail
		if (dl_v_reg[WL-1]) begin
			wv_next = 1'b1;
			wb_next = dl_bank_reg[WL-1];
			wr_next = row_reg[dl_bank_reg[WL-1]];
			wc_next = dl_col_reg[WL-1];
			wd_next = link.dq;
			bbank_next = dl_bank_reg[WL-1];
			bcol_next = {dl_col_reg[WL-1][CW-1:3], dl_col_reg[WL-1][2:0] + 3'h2};
			left_next = dl_chop_reg[WL-1] ? 3'(sdwr_pkg::BC4_CLKS - 1) : 3'(sdwr_pkg::BL8_CLKS - 1);
		end else if (left_reg != 3'h0) begin
			wv_next = 1'b1;
			wb_next = bbank_reg;
			wr_next = row_reg[bbank_reg];
			wc_next = bcol_reg;
			wd_next = link.dq;
			bcol_next = {bcol_reg[CW-1:3], bcol_reg[2:0] + 3'h2};
			left_next = left_reg - 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			open_reg <= '0;
			for (int b = 0; b < sdwr_pkg::BANKS; b++) begin
				row_reg[b] <= '0;
			end
			for (int i = 0; i < WL; i++) begin
				dl_v_reg[i] <= 1'b0;
				dl_chop_reg[i] <= 1'b0;
				dl_bank_reg[i] <= 3'h0;
				dl_col_reg[i] <= '0;
			end
			left_reg <= 3'h0;
			bbank_reg <= 3'h0;
			bcol_reg <= '0;
			rfc_reg <= 8'h00;
			mode_reg <= sdwr_pkg::BURST_BL8;
			rrow_reg <= '0;
			rpulse_reg <= 1'b0;
			wv_reg <= 1'b0;
			wb_reg <= 3'h0;
			wr_reg <= '0;
			wc_reg <= '0;
			wd_reg <= '0;
		end else begin
			open_reg <= open_next;
			row_reg <= row_next;
			dl_v_reg <= dl_v_next;
			dl_chop_reg <= dl_chop_next;
			dl_bank_reg <= dl_bank_next;
			dl_col_reg <= dl_col_next;
			left_reg <= left_next;
			bbank_reg <= bbank_next;
			bcol_reg <= bcol_next;
			rfc_reg <= rfc_next;
			mode_reg <= mode_next;
			rrow_reg <= rrow_next;
			rpulse_reg <= rpulse_next;
			wv_reg <= wv_next;
			wb_reg <= wb_next;
			wr_reg <= wr_next;
			wc_reg <= wc_next;
			wd_reg <= wd_next;
		end
	end

	assign wr_valid = wv_reg;
	assign wr_bank = wb_reg;
	assign wr_row = wr_reg;
	assign wr_col = wc_reg;
	assign wr_data = wd_reg;
	assign ref_pulse = rpulse_reg;
	assign ref_row = rrow_reg;
	assign ref_busy = (rfc_reg != 8'h00);
	assign mode_burst = mode_reg;
	assign banks_idle = (open_reg == '0);
endmodule

/* sdwr_if.sv */
// Purpose: Command, address and write data pins between controller and memory
// Assumes: Both ends share clk; data flows controller to memory only
// Notes: No two-way pins are modelled, reads are outside this block
`timescale 1ns/1ps
interface sdwr_if #(parameter int DW = sdwr_pkg::DW_DEF);
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [2:0] ba;
	logic [sdwr_pkg::ADDR_W-1:0] addr;
	logic [2*DW-1:0] dq;

	modport ctl (output cs_n, output ras_n, output cas_n, output we_n, output ba, output addr, output dq);
	modport dev (input cs_n, input ras_n, input cas_n, input we_n, input ba, input addr, input dq);
endinterface

/* sdwr_pkg.sv */
// Purpose: Shared constants, command codes and helpers for the write/refresh link
// Assumes: 100 MHz clock; two data beats carried per clock on a double-width data bus
// Notes: All timing cycle counts except TMRD_CYC derive from times in picoseconds
package sdwr_pkg;

	localparam int CLK_PS = 10000;
	localparam int TRP_PS = 15000;
	localparam int TRCD_PS = 15000;
	localparam int TWR_PS = 15000;
	localparam int WRITE_TO_READ_DELAY_PS = 7500;
	localparam int REFRESH_CYCLE_TIME_PS = 110000;
	localparam int REFRESH_INTERVAL_AVG_PS = 7800000;

	// Least times round up, the average interval rounds down
	localparam int TRP_CYC = (TRP_PS + CLK_PS - 1) / CLK_PS;
	localparam int TRCD_CYC = (TRCD_PS + CLK_PS - 1) / CLK_PS;
	localparam int TWR_CYC = (TWR_PS + CLK_PS - 1) / CLK_PS;
	localparam int WRITE_TO_READ_DELAY_CYC = (WRITE_TO_READ_DELAY_PS + CLK_PS - 1) / CLK_PS;
	localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_PS + CLK_PS - 1) / CLK_PS;
	localparam int REFRESH_INTERVAL_AVG_CYC = REFRESH_INTERVAL_AVG_PS / CLK_PS;
	localparam int TMRD_CYC = 4;

	localparam int AL_DEF = 0;
	localparam int CWL_DEF = 5;
	localparam int DW_DEF = 8;
	localparam int ADDR_W = 16;
	localparam int COL_W = 10;
	localparam int BANKS = 8;
	localparam int BURST_SEL_BIT = 12;
	localparam int PRE_ALL_BIT = 10;
	localparam int MAX_POSTPONE = 8;
	localparam int MAX_PULL_IN = 8;
	localparam int BL8_CLKS = 4;
	localparam int BC4_CLKS = 2;
	localparam int CHOP_RECOV_CLKS = 4;

	// Command pins {cs_n, ras_n, cas_n, we_n}
	typedef logic [3:0] sdwr_cmd_t;
	localparam sdwr_cmd_t CMD_MRS = 4'h0;
	localparam sdwr_cmd_t CMD_REF = 4'h1;
	localparam sdwr_cmd_t CMD_PRE = 4'h2;
	localparam sdwr_cmd_t CMD_ACT = 4'h3;
	localparam sdwr_cmd_t CMD_WR = 4'h4;
	localparam sdwr_cmd_t CMD_NOP = 4'h7;

	localparam logic [1:0] BURST_BL8 = 2'h0;
	localparam logic [1:0] BURST_OTF = 2'h1;
	localparam logic [1:0] BURST_BC4 = 2'h2;

	function automatic logic sdwr_is_chop(input logic [1:0] mode, input logic sel);
		sdwr_is_chop = (mode == BURST_BC4) || ((mode == BURST_OTF) && !sel);
	endfunction

	function automatic logic [7:0] sdwr_pairs(input logic chop);
		sdwr_pairs = chop ? 8'(BC4_CLKS) : 8'(BL8_CLKS);
	endfunction

endpackage

/* sdwr_props.sv */
// Purpose: Wire checks on the command and address pins between controller and memory
// Assumes: One clock; every command stands for one cycle and is sampled on its rising edge
// Notes: Distance counters saturate so long idle spells cannot wrap
`timescale 1ns/1ps
module sdwr_props #(
	parameter int AL = sdwr_pkg::AL_DEF,
	parameter int CAS_WRITE_LATENCY = sdwr_pkg::CWL_DEF,
	parameter int DW = sdwr_pkg::DW_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [sdwr_pkg::ADDR_W-1:0] addr,
	input wire logic [2*DW-1:0] dq
);
	localparam int WL = AL + CAS_WRITE_LATENCY;
	localparam int REFRESH_CYCLE_TIME = sdwr_pkg::REFRESH_CYCLE_TIME_CYC;
	localparam int PRECHARGE_TIME = sdwr_pkg::TRP_CYC;
	localparam int WRITE_RECOVERY_TIME = sdwr_pkg::TWR_CYC;
	localparam int GAP = 9 * sdwr_pkg::REFRESH_INTERVAL_AVG_CYC;
	localparam int WIN = 2 * sdwr_pkg::REFRESH_INTERVAL_AVG_CYC;
	logic [3:0] cmd;
	logic [15:0] since_ref_reg, since_pre_reg, since_wr_reg;
	logic open_reg, fchop_reg;
	logic [2:0] span_reg;
	logic [4:0] nref_reg;
	logic [3:0] hidx_reg;
	logic [31:0] cyc_reg;
	logic [31:0] hist_reg [16];
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	function automatic logic [15:0] sat(input logic [15:0] v);
		sat = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Starts past the no-command span so a mode load right after reset is legal
			since_ref_reg <= 16'h0014;
			since_pre_reg <= 16'hFFFF;
			since_wr_reg <= 16'hFFFF;
			open_reg <= 1'b0;
			fchop_reg <= 1'b0;
			span_reg <= 3'h4;
			nref_reg <= 5'h00;
			hidx_reg <= 4'h0;
			cyc_reg <= 32'h0000_0000;
		end else begin
			cyc_reg <= cyc_reg + 32'h0000_0001;
			since_ref_reg <= (cmd == sdwr_pkg::CMD_REF) ? 16'h0000 : sat(since_ref_reg);
			since_pre_reg <= (cmd == sdwr_pkg::CMD_PRE) ? 16'h0000 : sat(since_pre_reg);
			since_wr_reg <= (cmd == sdwr_pkg::CMD_WR) ? 16'h0000 : sat(since_wr_reg);
			if (cmd == sdwr_pkg::CMD_ACT) open_reg <= 1'b1;
			if (cmd == sdwr_pkg::CMD_PRE) open_reg <= 1'b0;
			if (cmd == sdwr_pkg::CMD_MRS && ba == 3'h0) fchop_reg <= (addr[1:0] == sdwr_pkg::BURST_BC4);
			// Only fixed chop ends recovery early; chop chosen per command keeps the full span
			if (cmd == sdwr_pkg::CMD_WR) span_reg <= fchop_reg ? 3'h2 : 3'h4;
			if (cmd == sdwr_pkg::CMD_REF) begin
				hist_reg[hidx_reg] <= cyc_reg;
				hidx_reg <= hidx_reg + 4'h1;
				if (nref_reg != 5'h10) nref_reg <= nref_reg + 5'h01;
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	cmd_legal_a: assert property (!cs_n |-> cmd != 4'h5 && cmd != 4'h6)
		else $error("undefined command on the pins");
	ref_idle_a: assert property (cmd == sdwr_pkg::CMD_REF |-> !open_reg && since_pre_reg >= PRECHARGE_TIME - 1)
		else $error("refresh with a bank open or precharge time short");
	ref_nop_a: assert property (since_ref_reg < REFRESH_CYCLE_TIME - 1 |-> cs_n || cmd == sdwr_pkg::CMD_NOP)
		else $error("command inside the refresh cycle time");
	ref_gap_a: assert property (since_ref_reg < GAP)
		else $error("refresh gap too long");
	ref_window_a: assert property (cmd == sdwr_pkg::CMD_REF && nref_reg == 5'h10 |->
		cyc_reg - hist_reg[hidx_reg] >= WIN)
		else $error("too many refreshes in the window");
	mrs_field_a: assert property (cmd == sdwr_pkg::CMD_MRS |-> ba == 3'h0 && addr[1:0] != 2'h3)
		else $error("bad burst field load");
	wr_recovery_a: assert property (cmd == sdwr_pkg::CMD_PRE |-> since_wr_reg >= WL + span_reg + WRITE_RECOVERY_TIME - 1)
		else $error("precharge before write recovery");
	wr_spacing_a: assert property (cmd == sdwr_pkg::CMD_WR |-> since_wr_reg >= 16'h0003)
		else $error("writes closer than four clocks");
endmodule
